/* File: core/iop_pkg.sv */
// Shared constants for the port, infrared and PWM block
package iop_pkg;
   // Port geometry
   localparam int PORT_COUNT = 4;
   localparam int PORT_WIDTH = 4;
   localparam int PIN_COUNT = 16;
   localparam int PWM_COUNT = 4;
   localparam int PWM_WIDTH = 8;
   localparam int ADDR_WIDTH = 4;
   localparam int DATA_WIDTH = 8;
   localparam int PWM_BASE_PIN = 8;

   // Register map, one 8-bit register per address
   localparam logic [3:0] ADDR_PORT_A_DATA = 4'h0;
   localparam logic [3:0] ADDR_PORT_A_DIR = 4'h1;
   localparam logic [3:0] ADDR_PORT_B_DATA = 4'h2;
   localparam logic [3:0] ADDR_PORT_B_DIR = 4'h3;
   localparam logic [3:0] ADDR_PORT_C_DATA = 4'h4;
   localparam logic [3:0] ADDR_PORT_C_DIR = 4'h5;
   localparam logic [3:0] ADDR_PORT_D_DATA = 4'h6;
   localparam logic [3:0] ADDR_PORT_D_DIR = 4'h7;
   localparam logic [3:0] ADDR_MODE = 4'h8;
   localparam logic [3:0] ADDR_STOP = 4'h9;
   localparam logic [3:0] ADDR_STATUS = 4'hA;
   localparam logic [3:0] ADDR_PWM_EN = 4'hB;
   localparam logic [3:0] ADDR_DUTY_0 = 4'hC;

   // Mode and status register fields
   localparam int MODE_IR_SEL_BIT = 1;
   localparam int MODE_IR_EN_BIT = 3;
   localparam int STATUS_STOP_BIT = 0;

   // Pin positions used by the infrared path
   localparam int PIN_B3 = 7;
   localparam int PIN_C3 = 11;
   localparam int PORT_C_INDEX = 2;
   localparam int BIT3 = 3;

   // Reset values
   localparam logic [3:0] PORT_RESET = 4'h0;
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [7:0] DATA_ZERO = 8'h00;

   // Carrier timing: clock rate and carrier frequency in Hz
   localparam int CLK_HZ = 10_000_000;
   localparam int IR_CARRIER_HZ = 38_500;
   localparam int IR_HALF_CYCLES = CLK_HZ / (2 * IR_CARRIER_HZ);
   localparam logic [7:0] IR_HALF_LAST = 8'(IR_HALF_CYCLES - 1);

   // Run state of the core clock
   typedef enum logic {IOP_RUN_ACTIVE, IOP_RUN_STOPPED} iop_run_e;
endpackage

/* File: core/iop_pwm.sv */
// One PWM channel with its own free-running counter
`timescale 1ns/1ps
module iop_pwm (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [iop_pkg::PWM_WIDTH-1:0] duty_in,
   output logic pwm_out
);
   // Period counter, wraps after 256 counts
   logic [iop_pkg::PWM_WIDTH-1:0] count;
   logic [iop_pkg::PWM_WIDTH-1:0] next_count;
   // Registered waveform
   logic next_pwm;

   always_comb begin
      next_count = count + 8'h01;
      // High while below duty, so duty zero stays low
      next_pwm = (count < duty_in);
   end

   // Register stage
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count <= 8'h00;
         pwm_out <= 1'b0;
      end else begin
         count <= next_count;
         pwm_out <= next_pwm;
      end
   end
endmodule

/* File: core/iop_top.sv */
// Four 4-bit ports with stop-mode wake, infrared carrier and PWM
`timescale 1ns/1ps
module iop_top (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [iop_pkg::ADDR_WIDTH-1:0] addr_in,
   input wire logic [iop_pkg::DATA_WIDTH-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [iop_pkg::DATA_WIDTH-1:0] rdata_out,
   input wire logic [iop_pkg::PIN_COUNT-1:0] pin_in,
   output logic [iop_pkg::PIN_COUNT-1:0] pin_out,
   output logic [iop_pkg::PIN_COUNT-1:0] pin_oe_out,
   output logic [iop_pkg::PIN_COUNT-1:0] pull_low_out,
   output logic clk_run_out
);
   // Port output latches and direction bits (one = output)
   logic [iop_pkg::PORT_WIDTH-1:0] port_data [iop_pkg::PORT_COUNT];
   logic [iop_pkg::PORT_WIDTH-1:0] port_dir [iop_pkg::PORT_COUNT];
   logic [iop_pkg::PORT_WIDTH-1:0] next_port_data [iop_pkg::PORT_COUNT];
   logic [iop_pkg::PORT_WIDTH-1:0] next_port_dir [iop_pkg::PORT_COUNT];
   // Mode fields
   logic ir_enable;
   logic ir_pin_select;
   logic next_ir_enable;
   logic next_ir_pin_select;
   // PWM steering and duty values
   logic [iop_pkg::PWM_COUNT-1:0] pwm_enable;
   logic [iop_pkg::PWM_COUNT-1:0] next_pwm_enable;
   logic [iop_pkg::PWM_WIDTH-1:0] duty [iop_pkg::PWM_COUNT];
   logic [iop_pkg::PWM_WIDTH-1:0] next_duty [iop_pkg::PWM_COUNT];
   logic [iop_pkg::PWM_COUNT-1:0] pwm_wave;
   // Stop-mode state and last sampled pins
   iop_pkg::iop_run_e run_state;
   iop_pkg::iop_run_e next_run_state;
   logic [iop_pkg::PIN_COUNT-1:0] last_pins;
   logic [iop_pkg::PIN_COUNT-1:0] next_last_pins;
   // Carrier generator
   logic [7:0] car_count;
   logic [7:0] next_car_count;
   logic carrier;
   logic next_carrier;
   // Registered outputs
   logic [iop_pkg::DATA_WIDTH-1:0] next_rdata;
   logic [iop_pkg::PIN_COUNT-1:0] next_pin_out;
   logic [iop_pkg::PIN_COUNT-1:0] next_pin_oe;
   logic [iop_pkg::PIN_COUNT-1:0] next_pull_low;
   logic next_clk_run;
   // Flattened views of the port arrays
   logic [iop_pkg::PIN_COUNT-1:0] flat_data;
   logic [iop_pkg::PIN_COUNT-1:0] flat_dir;
   logic port_c_bit3_data;
   logic ir_modulated;

   // Port number addressed by a data or direction register
   function automatic logic [1:0] port_of(input logic [3:0] a);
      port_of = a[2:1];
   endfunction

   // True when the address hits a port data or direction register
   function automatic logic is_port_reg(input logic [3:0] a);
      is_port_reg = (a < iop_pkg::ADDR_MODE);
   endfunction

   // channels bound to port c bits
   genvar g;
   generate
      for (g = 0; g < iop_pkg::PWM_COUNT; g = g + 1) begin : gen_pwm
         iop_pwm u_pwm (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .duty_in(duty[g]),
            .pwm_out(pwm_wave[g])
         );
      end
   endgenerate

   // Flatten ports, port a in the low nibble
   always_comb begin
      for (int p = 0; p < iop_pkg::PORT_COUNT; p++) begin
         flat_data[p*iop_pkg::PORT_WIDTH +: iop_pkg::PORT_WIDTH] =
            port_data[p];
         flat_dir[p*iop_pkg::PORT_WIDTH +: iop_pkg::PORT_WIDTH] =
            port_dir[p];
      end
   end

   // Register writes
   always_comb begin
      for (int p = 0; p < iop_pkg::PORT_COUNT; p++) begin
         next_port_data[p] = port_data[p];
         next_port_dir[p] = port_dir[p];
      end
      for (int c = 0; c < iop_pkg::PWM_COUNT; c++) begin
         next_duty[c] = duty[c];
      end
      next_ir_enable = ir_enable;
      next_ir_pin_select = ir_pin_select;
      next_pwm_enable = pwm_enable;
      if (wr_in) begin
         if (is_port_reg(addr_in)) begin
            if (addr_in[0]) begin
               next_port_dir[port_of(addr_in)] =
                  wdata_in[iop_pkg::PORT_WIDTH-1:0];
            end else begin
               next_port_data[port_of(addr_in)] =
                  wdata_in[iop_pkg::PORT_WIDTH-1:0];
            end
         end else if (addr_in == iop_pkg::ADDR_MODE) begin
            next_ir_enable = wdata_in[iop_pkg::MODE_IR_EN_BIT];
            next_ir_pin_select = wdata_in[iop_pkg::MODE_IR_SEL_BIT];
         end else if (addr_in == iop_pkg::ADDR_PWM_EN) begin
            next_pwm_enable = wdata_in[iop_pkg::PWM_COUNT-1:0];
         end else if (addr_in >= iop_pkg::ADDR_DUTY_0) begin
            next_duty[addr_in[1:0]] = wdata_in;
         end
      end
   end

   // Control registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         for (int p = 0; p < iop_pkg::PORT_COUNT; p++) begin
            port_data[p] <= iop_pkg::PORT_RESET;
            // All pins start as pulled-low inputs
            port_dir[p] <= iop_pkg::PORT_RESET;
         end
         for (int c = 0; c < iop_pkg::PWM_COUNT; c++) begin
            duty[c] <= iop_pkg::DUTY_RESET;
         end
         ir_enable <= 1'b0;
         ir_pin_select <= 1'b0;
         pwm_enable <= 4'h0;
      end else begin
         for (int p = 0; p < iop_pkg::PORT_COUNT; p++) begin
            port_data[p] <= next_port_data[p];
            port_dir[p] <= next_port_dir[p];
         end
         for (int c = 0; c < iop_pkg::PWM_COUNT; c++) begin
            duty[c] <= next_duty[c];
         end
         ir_enable <= next_ir_enable;
         ir_pin_select <= next_ir_pin_select;
         pwm_enable <= next_pwm_enable;
      end
   end

   // Stop mode and wake detection
   // Driven pins that toggle also wake, as a real pad edge would
   always_comb begin
      next_run_state = run_state;
      // Pins are synchronous, so one snapshot suffices
      next_last_pins = pin_in;
      case (run_state)
         iop_pkg::IOP_RUN_ACTIVE: begin
            if (wr_in && addr_in == iop_pkg::ADDR_STOP) begin
               next_run_state = iop_pkg::IOP_RUN_STOPPED;
            end
         end
         iop_pkg::IOP_RUN_STOPPED: begin
            if (pin_in != last_pins) begin
               next_run_state = iop_pkg::IOP_RUN_ACTIVE;
            end
         end
         default: next_run_state = iop_pkg::IOP_RUN_ACTIVE;
      endcase
      next_clk_run = (next_run_state == iop_pkg::IOP_RUN_ACTIVE);
   end

   // Stop state registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         run_state <= iop_pkg::IOP_RUN_ACTIVE;
         last_pins <= 16'h0000;
         clk_run_out <= 1'b1;
      end else begin
         run_state <= next_run_state;
         last_pins <= next_last_pins;
         clk_run_out <= next_clk_run;
      end
   end

   always_comb begin
      next_car_count = car_count + 8'h01;
      next_carrier = carrier;
      if (car_count == iop_pkg::IR_HALF_LAST) begin
         next_car_count = 8'h00;
         next_carrier = ~carrier;
      end
   end

   // Carrier registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         car_count <= 8'h00;
         carrier <= 1'b0;
      end else begin
         car_count <= next_car_count;
         carrier <= next_carrier;
      end
   end

   // Pin drive: plain data, PWM, then infrared override
   always_comb begin
      port_c_bit3_data = port_data[iop_pkg::PORT_C_INDEX][iop_pkg::BIT3];
      ir_modulated = port_c_bit3_data & carrier;
      next_pin_out = flat_data;
      // drive only output pins, pull the rest low
      next_pin_oe = flat_dir;
      next_pull_low = ~flat_dir;
      for (int c = 0; c < iop_pkg::PWM_COUNT; c++) begin
         if (pwm_enable[c]) begin
            next_pin_out[iop_pkg::PWM_BASE_PIN + c] = pwm_wave[c];
         end
      end
      if (ir_enable) begin
         if (ir_pin_select) begin
            next_pin_out[iop_pkg::PIN_B3] = ir_modulated;
         end else begin
            next_pin_out[iop_pkg::PIN_C3] = ir_modulated;
         end
      end
   end

   // Pin output registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pin_out <= 16'h0000;
         pin_oe_out <= 16'h0000;
         pull_low_out <= 16'hFFFF;
      end else begin
         pin_out <= next_pin_out;
         pin_oe_out <= next_pin_oe;
         pull_low_out <= next_pull_low;
      end
   end

   // Read mux; data valid only in the cycle after the strobe
   always_comb begin
      next_rdata = iop_pkg::DATA_ZERO;
      if (rd_in) begin
         if (is_port_reg(addr_in)) begin
            if (addr_in[0]) begin
               next_rdata = {4'h0, port_dir[port_of(addr_in)]};
            end else begin
               // Inputs show the pin, outputs the latch
               next_rdata = {4'h0,
                  (pin_in[port_of(addr_in)*iop_pkg::PORT_WIDTH +:
                   iop_pkg::PORT_WIDTH] &
                   ~port_dir[port_of(addr_in)]) |
                  (port_data[port_of(addr_in)] &
                   port_dir[port_of(addr_in)])};
            end
         end else if (addr_in == iop_pkg::ADDR_MODE) begin
            next_rdata[iop_pkg::MODE_IR_EN_BIT] = ir_enable;
            next_rdata[iop_pkg::MODE_IR_SEL_BIT] = ir_pin_select;
         end else if (addr_in == iop_pkg::ADDR_STATUS) begin
            next_rdata[iop_pkg::STATUS_STOP_BIT] =
               (run_state == iop_pkg::IOP_RUN_STOPPED);
         end else if (addr_in == iop_pkg::ADDR_PWM_EN) begin
            next_rdata = {4'h0, pwm_enable};
         end else if (addr_in >= iop_pkg::ADDR_DUTY_0) begin
            next_rdata = duty[addr_in[1:0]];
         end
         // Stop address reads as zero
      end
   end

   // Read data register
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rdata_out <= iop_pkg::DATA_ZERO;
      end else begin
         rdata_out <= next_rdata;
      end
   end

   // Clock gating itself sits outside; clk_run_out only requests it
endmodule

/* File: verif/iop_top_sva.sv */
// Assertions on the port block pins and register bus
`timescale 1ns/1ps
module iop_top_sva (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe_out,
   input wire logic [15:0] pull_low_out,
   input wire logic clk_run_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic [7:0] mode_sh; // Shadow of the mode register
   logic [3:0] cd_sh; // Shadow of port c data
   logic [7:0] run_len; // Cycles pin b3 held its level
   logic ir7;
   assign ir7 = mode_sh[3] & mode_sh[1] & cd_sh[3];
   // Shadows follow bus writes; run length restarts on any change
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         mode_sh <= 8'h00;
         cd_sh <= 4'h0;
      end else if (wr_in && addr_in == 4'h8) begin
         mode_sh <= wdata_in;
      end else if (wr_in && addr_in == 4'h4) begin
         cd_sh <= wdata_in[3:0];
      end
      run_len <= (!ir7 || $changed(pin_out[7])) ? 8'h00 : run_len + 8'h01;
   end
   sequence s_stop_wr;
      wr_in && addr_in == 4'h9 && clk_run_out;
   endsequence
   property p_rd_zero; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
   property p_pull; pull_low_out == ~pin_oe_out; endproperty
   property p_stop; s_stop_wr |=> !clk_run_out; endproperty
   property p_wake;
      !clk_run_out && pin_in != $past(pin_in) |=> clk_run_out;
   endproperty
   property p_stay; !clk_run_out && $stable(pin_in) |=> !clk_run_out;
   endproperty
   property p_dir; wr_in && addr_in == 4'h1 |->
      ##2 pin_oe_out[3:0] == $past(wdata_in[3:0], 2); endproperty
   property p_rd_dir; rd_in && addr_in == 4'h1 |=>
      rdata_out[3:0] == pin_oe_out[3:0]; endproperty
   // Carrier half period is 129 cycles plus a short pipeline
   property p_carrier; ir7 |-> run_len <= 8'd131; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("stray rdata");
   a_pull: assert property (p_pull) else $error("pull mismatch");
   a_stop: assert property (p_stop) else $error("no stop");
   a_wake: assert property (p_wake) else $error("no wake");
   a_stay: assert property (p_stay) else $error("woke early");
   a_dir: assert property (p_dir) else $error("oe not set");
   a_rd_dir: assert property (p_rd_dir) else $error("dir read");
   a_carrier: assert property (p_carrier) else $error("no carrier");
endmodule

/* File: verif/iop_pin_model.sv */
// Model of keys and loads hanging on the sixteen pins
`timescale 1ns/1ps
module iop_pin_model (
   input wire logic clk_in,
   input wire logic [15:0] pin_out_in,
   input wire logic [15:0] pin_oe_in,
   input wire logic [15:0] pull_low_in,
   input wire logic [15:0] key_in,
   input wire logic [15:0] key_en_in,
   output logic [15:0] level_out
);
   logic [15:0] last; // Level seen last cycle
   always_ff @(posedge clk_in) last <= level_out;
   always_comb
      for (int i = 0; i < 16; i++)
         level_out[i] = pin_oe_in[i] ? pin_out_in[i] :
            key_en_in[i] ? key_in[i] : pull_low_in[i] ? 1'b0 : ~last[i];
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the port, infrared and PWM block
`timescale 1ns/1ps
module tb_top;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [15:0] key = 16'h0000; // Key levels
   logic [15:0] key_en = 16'h0000; // Key pressed or held
   logic [7:0] rdata_out;
   logic [15:0] pin_in, pin_out, pin_oe_out, pull_low_out;
   logic clk_run_out;
   int err_total = 0;
   int n_compared = 0;
   always #50 clk_in = ~clk_in;
   iop_top iop_top_inst (.clk_in(clk_in), .reset_in(reset_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_out(pin_oe_out), .pull_low_out(pull_low_out),
      .clk_run_out(clk_run_out));
   iop_pin_model iop_pin_model_inst (.clk_in(clk_in), .pin_out_in(pin_out),
      .pin_oe_in(pin_oe_out), .pull_low_in(pull_low_out), .key_in(key),
      .key_en_in(key_en), .level_out(pin_in));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk({8'h00, rdata_out}, {8'h00, exp});
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic t_ports;
      for (int p = 0; p < 4; p++) begin
         wr(4'(2 * p + 1), 8'h05);
         wr(4'(2 * p), 8'h0F);
      end
      settle(2);
      chk(pin_oe_out, 16'h5555);
      chk(pull_low_out, 16'hAAAA);
      chk(pin_out & 16'h5555, 16'h5555);
      for (int p = 0; p < 4; p++) rd(4'(2 * p), 8'h05);
      for (int p = 0; p < 4; p++) rd(4'(2 * p + 1), 8'h05);
      wr(4'hA, 8'h01);
      rd(4'hA, 8'h00);
      rd(4'h9, 8'h00);
      $display("test ports done");
   endtask
   // Stop, then wake on a rising and then a falling key edge
   task automatic t_stop;
      for (int v = 1; v >= 0; v--) begin
         wr(4'h9, 8'h00);
         settle(2);
         rd(4'hA, 8'h01);
         settle(20);
         chk({15'h0, clk_run_out}, 16'h0000);
         @(posedge clk_in);
         key_en[1] <= 1'b1;
         key[1] <= 1'(v);
         settle(2);
         chk({15'h0, clk_run_out}, 16'h0001);
         rd(4'h0, 8'(5 + 2 * v));
      end
      $display("test stop done");
   endtask
   task automatic t_pwm;
      logic [7:0] duty [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
      int cnt [4] = '{0, 0, 0, 0};
      wr(4'h5, 8'h0F);
      wr(4'hB, 8'h0F);
      for (int n = 0; n < 4; n++) wr(4'(12 + n), duty[n]);
      settle(4);
      repeat (256) begin
         @(negedge clk_in);
         for (int n = 0; n < 4; n++) cnt[n] += pin_out[8 + n];
      end
      for (int n = 0; n < 4; n++) chk(16'(cnt[n]), 16'(duty[n]));
      for (int n = 0; n < 4; n++) rd(4'(12 + n), duty[n]);
      rd(4'hB, 8'h0F);
      wr(4'hB, 8'h00);
      settle(2);
      chk({12'h000, pin_out[11:8]}, 16'h000F);
      $display("test pwm done");
   endtask
   // Level 2 means carrier expected, else a steady level
   task automatic obs(input int b, input logic [1:0] e);
      int chg = 0;
      int t [2] = '{0, 0};
      logic last;
      @(negedge clk_in);
      last = pin_out[b];
      for (int i = 0; i < 400; i++) begin
         @(negedge clk_in);
         if (pin_out[b] !== last && chg < 2) begin
            t[chg] = i;
            chg++;
         end
         last = pin_out[b];
      end
      if (e == 2'd2) chk(16'(t[1] - t[0]), 16'd129);
      else chk({15'h0, pin_out[b]} | 16'(chg << 4), 16'(e));
   endtask
   task automatic t_ir;
      logic [7:0] md [5] = '{8'h08, 8'h0A, 8'h0A, 8'h02, 8'h00};
      logic [3:0] cd [5] = '{4'hF, 4'hF, 4'h7, 4'hF, 4'hF};
      logic [1:0] e7 [5] = '{2'd0, 2'd2, 2'd0, 2'd0, 2'd0};
      logic [1:0] e11 [5] = '{2'd2, 2'd1, 2'd0, 2'd1, 2'd1};
      wr(4'h3, 8'h0F);
      wr(4'h2, 8'h00);
      for (int s = 0; s < 5; s++) begin
         wr(4'h8, md[s]);
         wr(4'h4, {4'h0, cd[s]});
         settle(3);
         obs(7, e7[s]);
         obs(11, e11[s]);
         rd(4'h8, md[s]);
      end
      $display("test ir done");
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      chk(pull_low_out, 16'hFFFF);
      chk({15'h0, clk_run_out}, 16'h0001);
      rd(4'hF, 8'h00);
      t_ports;
      t_stop;
      t_pwm;
      t_ir;
      final_report;
   end
   // Watchdog well beyond the expected run
   initial begin
      #3_000_000;
      err_total++;
      final_report;
   end
endmodule
bind iop_top iop_top_sva iop_top_sva_inst (.clk_in(clk_in),
   .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe_out(pin_oe_out),
   .pull_low_out(pull_low_out), .clk_run_out(clk_run_out));
